// file: include/lhgd_defines.svh
// offsets, field positions, reset values and codes of the low/high-g detector
`ifndef LHGD_DEFINES_SVH
`define LHGD_DEFINES_SVH

`define LHGD_OFS_LOW_THR_MSB  8'h00
`define LHGD_OFS_LOW_THR_LSB  8'h01
`define LHGD_OFS_LOW_MIN      8'h02
`define LHGD_OFS_LOW_CFG      8'h03
`define LHGD_OFS_HIGH_THR_MSB 8'h04
`define LHGD_OFS_HIGH_THR_LSB 8'h05
`define LHGD_OFS_STATUS       8'h00

`define LHGD_RST_LOW_THR      16'h03E8
`define LHGD_RST_LOW_MIN      8'h08
`define LHGD_RST_LOW_CFG      8'h17
`define LHGD_RST_HIGH_THR     16'h1F40
`define LHGD_RST_HIGH_MIN     8'h08
`define LHGD_RST_HIGH_CFG     8'h1F
`define LHGD_CFG_MASK         8'h1F

`define LHGD_APP_HIGH         8'h08
`define LHGD_APP_LOW          8'h09
`define LHGD_APP_POWER        8'h12
`define LHGD_OFS_POWER_SLEEP  8'h06
`define LHGD_BIT_SLEEP        0

`define LHGD_CMD_CFG_WRITE    8'h20
`define LHGD_CMD_STATUS_READ  8'h30
`define LHGD_ST_COMPLETE      8'h80
`define LHGD_ST_ERROR         8'h84

`define LHGD_MB_APP           0
`define LHGD_MB_CMD           1
`define LHGD_MB_OFS           2
`define LHGD_MB_CNT           3
`define LHGD_MB_DATA          4

`endif

// file: include/lhgd_pkg.sv
// types shared by the low/high-g detector
package lhgd_pkg;

	// one accelerometer sample, two's complement per axis
	typedef struct packed {
		logic [15:0] z;
		logic [15:0] y;
		logic [15:0] x;
	} lhgd_sample_t;

	// status byte layout
	typedef struct packed {
		logic       high_combined_flag;
		logic [2:0] high_flags;
		logic       low_combined_flag;
		logic [2:0] low_flags;
	} lhgd_status_t;

	// detect configuration byte layout
	typedef struct packed {
		logic [2:0] reserved;
		logic       debounce_mode_select;
		logic       combine_select;
		logic [2:0] enables;
	} lhgd_cfg_t;

endpackage

// file: design/lhgd_detector.sv
// low/high-g detector with its mailbox command port
`timescale 1ns/100ps
`default_nettype none
`include "lhgd_defines.svh"

module lhgd_detector
	import lhgd_pkg::*;
#(
	parameter int         MBOX_DEPTH     = 32,
	parameter logic [7:0] HIGH_MIN_COUNT = `LHGD_RST_HIGH_MIN,
	parameter logic [7:0] HIGH_CONFIG    = `LHGD_RST_HIGH_CFG
) (
	input  wire logic                          CLK,
	input  wire logic                          ARST_N,
	input  wire logic                          SAMPLE_VALID,
	input  wire lhgd_sample_t                  SAMPLE,
	input  wire logic                          MB_WR,
	input  wire logic [$clog2(MBOX_DEPTH)-1:0] MB_ADDR,
	input  wire logic [7:0]                    MB_WDATA,
	input  wire logic                          MB_RD,
	output logic      [7:0]                    MB_RDATA,
	output logic                               MB_RVALID,
	output logic                               CMD_DONE,
	output lhgd_status_t                       STATUS,
	output logic                               ASLEEP
);

	localparam int AW = $clog2(MBOX_DEPTH);
	localparam int NDATA = MBOX_DEPTH - `LHGD_MB_DATA;
	localparam logic [7:0] DATA_CAP = 8'(NDATA);

	// refuse mailbox sizes the index logic cannot serve
	if (MBOX_DEPTH < 8 || MBOX_DEPTH > 256 || (1 << AW) != MBOX_DEPTH) begin : g_chk
		$error("MBOX_DEPTH must be a power of two from 8 to 256");
	end

	// fixed high-g settings: reserved bits clear, count inside 1 to 255
	if (HIGH_CONFIG[7:5] != 3'h0 || HIGH_MIN_COUNT == 8'h00) begin : g_chk_high
		$error("HIGH_CONFIG reserved bits must be zero and HIGH_MIN_COUNT nonzero");
	end

	// magnitude with the most negative code saturated
	function automatic logic [15:0] magnitude(input logic [15:0] v);
		if (!v[15])
			return v;
		if (v == 16'h8000)
			return 16'h7FFF;
		return 16'(~v + 16'h0001);
	endfunction

	// minimum count with zero treated as one
	function automatic logic [7:0] limit(input logic [7:0] m);
		return (m == 8'h00) ? 8'h01 : m;
	endfunction

	// combined flag over enabled axes; AND with nothing enabled stays low
	function automatic logic combine(
		input logic [2:0] flags,
		input logic [2:0] en,
		input logic       use_or
	);
		if (use_or)
			return |flags;
		return (en != 3'h0) && (flags == en);
	endfunction

	// one debounce step of an axis counter
	function automatic logic [7:0] debounce(
		input logic       cand,
		input logic       en,
		input logic       dec,
		input logic [7:0] cnt,
		input logic [7:0] min
	);
		if (!en)
			return 8'h00;
		if (cand)
			return (cnt == 8'hFF) ? cnt : 8'(cnt + 8'h01);
		if (cnt >= limit(min))
			return 8'h00;
		if (dec)
			return (cnt == 8'h00) ? cnt : 8'(cnt - 8'h01);
		return 8'h00;
	endfunction

	// configuration and power state
	logic [15:0]  low_thr_r;
	logic [15:0]  low_thr_nxt;
	logic [7:0]   low_min_r;
	logic [7:0]   low_min_nxt;
	lhgd_cfg_t    low_cfg_r;
	lhgd_cfg_t    low_cfg_nxt;
	logic [15:0]  high_thr_r;
	logic [15:0]  high_thr_nxt;
	logic         sleep_r;
	logic         sleep_nxt;

	// mailbox state
	logic [7:0]   mbox_r   [MBOX_DEPTH];
	logic [7:0]   mbox_nxt [MBOX_DEPTH];
	logic [7:0]   rdata_r;
	logic [7:0]   rdata_nxt;
	logic         rvalid_r;
	logic         rvalid_nxt;
	logic         done_r;
	logic         done_nxt;

	// mailbox decode helpers
	logic [7:0]   app;
	logic [7:0]   cmd;
	logic [7:0]   ofs;
	logic [7:0]   cnt;
	logic [7:0]   actual;
	logic [7:0]   byte_ofs;
	logic [7:0]   byte_val;
	logic         app_lhg;
	logic         wr_go;
	logic         rd_go;

	// detection state
	logic [7:0]   dcnt_r   [6];
	logic [7:0]   dcnt_nxt [6];
	lhgd_status_t status_r;
	lhgd_status_t status_nxt;
	logic [2:0]   low_f;
	logic [2:0]   high_f;
	logic [2:0]   low_en;
	logic [2:0]   high_en;
	logic [15:0]  mag [3];
	logic [2:0]   low_cand;
	logic [2:0]   high_cand;

	// mailbox command handling and configuration writes
	always_comb begin
		mbox_nxt     = mbox_r;
		low_thr_nxt  = low_thr_r;
		low_min_nxt  = low_min_r;
		low_cfg_nxt  = low_cfg_r;
		high_thr_nxt = high_thr_r;
		sleep_nxt    = sleep_r;
		done_nxt     = 1'b0;
		byte_ofs     = 8'h00;
		byte_val     = 8'h00;
		if (MB_WR) begin
			mbox_nxt[MB_ADDR] = MB_WDATA;
		end
		app     = mbox_nxt[`LHGD_MB_APP];
		cmd     = mbox_nxt[`LHGD_MB_CMD];
		ofs     = mbox_nxt[`LHGD_MB_OFS];
		cnt     = mbox_nxt[`LHGD_MB_CNT];
		actual  = (cnt > DATA_CAP) ? DATA_CAP : cnt;
		app_lhg = (app == `LHGD_APP_LOW) || (app == `LHGD_APP_HIGH);
		// write runs on its last data byte
		wr_go = MB_WR && (cmd == `LHGD_CMD_CFG_WRITE) && (MB_ADDR >= AW'(`LHGD_MB_CNT)) &&
			(9'(MB_ADDR) == 9'(cnt) + 9'(`LHGD_MB_CNT));
		// read runs on the count byte
		rd_go = MB_WR && (cmd == `LHGD_CMD_STATUS_READ) && (MB_ADDR == AW'(`LHGD_MB_CNT));
		if (wr_go) begin
			done_nxt = 1'b1;
			mbox_nxt[`LHGD_MB_CMD] = (app_lhg || app == `LHGD_APP_POWER) ?
				`LHGD_ST_COMPLETE : `LHGD_ST_ERROR;
			for (int k = 0; k < NDATA; k++) begin
				if (8'(k) < cnt) begin
					byte_ofs = 8'(ofs + 8'(k));
					byte_val = mbox_nxt[`LHGD_MB_DATA + k];
					if (app_lhg) begin
						case (byte_ofs)
							`LHGD_OFS_LOW_THR_MSB: begin
								low_thr_nxt[15:8] = byte_val;
							end
							`LHGD_OFS_LOW_THR_LSB: begin
								low_thr_nxt[7:0] = byte_val;
							end
							`LHGD_OFS_LOW_MIN: begin
								low_min_nxt = byte_val;
							end
							`LHGD_OFS_LOW_CFG: begin
								low_cfg_nxt = byte_val & `LHGD_CFG_MASK;
							end
							`LHGD_OFS_HIGH_THR_MSB: begin
								high_thr_nxt[15:8] = byte_val;
							end
							`LHGD_OFS_HIGH_THR_LSB: begin
								high_thr_nxt[7:0] = byte_val;
							end
							default: begin
							end
						endcase
					end else if (app == `LHGD_APP_POWER && byte_ofs == `LHGD_OFS_POWER_SLEEP) begin
						sleep_nxt = byte_val[`LHGD_BIT_SLEEP];
					end
				end
			end
		end
		// status read answer laid into the mailbox
		if (rd_go) begin
			done_nxt = 1'b1;
			mbox_nxt[`LHGD_MB_CMD] = app_lhg ? `LHGD_ST_COMPLETE : `LHGD_ST_ERROR;
			mbox_nxt[`LHGD_MB_OFS] = cnt;
			mbox_nxt[`LHGD_MB_CNT] = app_lhg ? actual : 8'h00;
			for (int k = 0; k < NDATA; k++) begin
				if (app_lhg && 8'(k) < actual) begin
					mbox_nxt[`LHGD_MB_DATA + k] = (8'(ofs + 8'(k)) == `LHGD_OFS_STATUS) ?
						status_r : 8'h00;
				end
			end
		end
	end

	// mailbox read port, one cycle behind the request
	always_comb begin
		rvalid_nxt = MB_RD;
		rdata_nxt  = rdata_r;
		if (MB_RD) begin
			rdata_nxt = mbox_r[MB_ADDR]; // old byte wins over a same-cycle write
		end
	end

	// read port registers
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// mailbox and configuration registers
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < MBOX_DEPTH; i++) begin
				mbox_r[i] <= 8'h00;
			end
			low_thr_r  <= `LHGD_RST_LOW_THR;
			low_min_r  <= `LHGD_RST_LOW_MIN;
			low_cfg_r  <= `LHGD_RST_LOW_CFG;
			high_thr_r <= `LHGD_RST_HIGH_THR;
			sleep_r    <= 1'b1;
			done_r     <= 1'b0;
		end else begin
			mbox_r     <= mbox_nxt;
			low_thr_r  <= low_thr_nxt;
			low_min_r  <= low_min_nxt;
			low_cfg_r  <= low_cfg_nxt;
			high_thr_r <= high_thr_nxt;
			sleep_r    <= sleep_nxt;
			done_r     <= done_nxt;
		end
	end

	assign low_en  = low_cfg_r.enables;
	assign high_en = HIGH_CONFIG[2:0];

	// axis magnitudes and threshold candidates
	always_comb begin
		mag[0] = magnitude(SAMPLE.x);
		mag[1] = magnitude(SAMPLE.y);
		mag[2] = magnitude(SAMPLE.z);
		for (int a = 0; a < 3; a++) begin
			low_cand[a]  = mag[a] < low_thr_r;
			high_cand[a] = mag[a] > high_thr_r;
		end
	end

	// one algorithm cycle per accepted sample
	always_comb begin
		dcnt_nxt   = dcnt_r;
		status_nxt = status_r;
		low_f      = 3'h0;
		high_f     = 3'h0;
		if (SAMPLE_VALID && !sleep_r) begin
			for (int a = 0; a < 3; a++) begin
				dcnt_nxt[a] = debounce(low_cand[a], low_en[a],
					low_cfg_r.debounce_mode_select, dcnt_r[a], low_min_r);
				dcnt_nxt[a + 3] = debounce(high_cand[a], high_en[a],
					HIGH_CONFIG[4], dcnt_r[a + 3], HIGH_MIN_COUNT);
				low_f[a]  = low_en[a] && (dcnt_nxt[a] >= limit(low_min_r));
				high_f[a] = high_en[a] && (dcnt_nxt[a + 3] >= limit(HIGH_MIN_COUNT));
			end
			status_nxt.low_flags  = low_f;
			status_nxt.high_flags = high_f;
			// combine over enabled axes only
			status_nxt.low_combined_flag  = combine(low_f, low_en,
				low_cfg_r.combine_select);
			status_nxt.high_combined_flag = combine(high_f, high_en, HIGH_CONFIG[3]);
		end
	end

	// detection registers
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < 6; i++) begin
				dcnt_r[i] <= 8'h00;
			end
			status_r <= 8'h00;
		end else begin
			dcnt_r   <= dcnt_nxt;
			status_r <= status_nxt;
		end
	end

	// port drive from registers
	assign MB_RDATA  = rdata_r;
	assign MB_RVALID = rvalid_r;
	assign CMD_DONE  = done_r;
	assign STATUS    = status_r;
	assign ASLEEP    = sleep_r;

endmodule
`default_nettype wire

// file: test/lhgd_detector_props.sv
// port checker of the low/high-g detector
`timescale 1ns/100ps
`default_nettype none
module lhgd_detector_props
	import lhgd_pkg::*;
#(
	parameter int         MBOX_DEPTH     = 32,
	parameter logic [7:0] HIGH_MIN_COUNT = 8'h08,
	parameter logic [7:0] HIGH_CONFIG    = 8'h1F
) (
	input wire logic                          CLK,
	input wire logic                          ARST_N,
	input wire logic                          SAMPLE_VALID,
	input wire lhgd_sample_t                  SAMPLE,
	input wire logic                          MB_WR,
	input wire logic [$clog2(MBOX_DEPTH)-1:0] MB_ADDR,
	input wire logic [7:0]                    MB_WDATA,
	input wire logic                          MB_RD,
	input wire logic [7:0]                    MB_RDATA,
	input wire logic                          MB_RVALID,
	input wire logic                          CMD_DONE,
	input wire lhgd_status_t                  STATUS,
	input wire logic                          ASLEEP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// mailbox answers and completion
	property p_rd_ans; MB_RD |=> MB_RVALID; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
	property p_rd_hold; !MB_RD |=> $stable(MB_RDATA); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_done; CMD_DONE |-> $past(MB_WR); endproperty
	a_done: assert property (p_done) else $error("done without write");
	// sleep state only moved by a write, status frozen while asleep
	property p_sleep; !$stable(ASLEEP) |-> $past(MB_WR); endproperty
	a_sleep: assert property (p_sleep) else $error("sleep moved alone");
	property p_frozen; ASLEEP |=> $stable(STATUS); endproperty
	a_frozen: assert property (p_frozen) else $error("status moved asleep");
	// combined flags against the axis flags
	property p_low_comb; STATUS.low_combined_flag |-> STATUS.low_flags != 3'h0; endproperty
	a_low_comb: assert property (p_low_comb) else $error("low combined alone");
	property p_high_comb; STATUS.high_combined_flag == (HIGH_CONFIG[3] ? |STATUS.high_flags
		: HIGH_CONFIG[2:0] != 3'h0 && STATUS.high_flags == HIGH_CONFIG[2:0]); endproperty
	a_high_comb: assert property (p_high_comb) else $error("high combined wrong");
	property p_high_rise;
		(STATUS.high_flags & ~$past(STATUS.high_flags)) != 3'h0 |-> $past(SAMPLE_VALID);
	endproperty
	a_high_rise: assert property (p_high_rise) else $error("high flag without sample");
endmodule
bind lhgd_detector lhgd_detector_props #(.MBOX_DEPTH(MBOX_DEPTH),
	.HIGH_MIN_COUNT(HIGH_MIN_COUNT), .HIGH_CONFIG(HIGH_CONFIG)) i_lhgd_detector_props (
	.CLK(CLK), .ARST_N(ARST_N), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE(SAMPLE), .MB_WR(MB_WR),
	.MB_ADDR(MB_ADDR), .MB_WDATA(MB_WDATA), .MB_RD(MB_RD), .MB_RDATA(MB_RDATA),
	.MB_RVALID(MB_RVALID), .CMD_DONE(CMD_DONE), .STATUS(STATUS), .ASLEEP(ASLEEP));
`default_nettype wire

// file: test/lhgd_host_model.sv
// host model issuing mailbox commands and reads
`timescale 1ns/100ps
`default_nettype none
module lhgd_host_model (
	input  wire logic       clk,
	output var  logic       mb_wr = 1'b0,
	output var  logic [4:0] mb_addr = 5'h00,
	output var  logic [7:0] mb_wdata = 8'h00,
	output var  logic       mb_rd = 1'b0,
	input  wire logic [7:0] mb_rdata,
	input  wire logic       mb_rvalid,
	input  wire logic       cmd_done
);
	// one command byte by byte, with idle gaps now and then
	task automatic send(input logic [7:0] b[$], output logic done);
		for (int i = 0; i < b.size(); i++) begin
			@(posedge clk);
			if ($urandom_range(0, 3) == 0) begin
				mb_wr <= 1'b0;
				@(posedge clk);
			end
			mb_wr    <= 1'b1;
			mb_addr  <= i[4:0];
			mb_wdata <= b[i];
		end
		@(posedge clk);
		mb_wr    <= 1'b0;
		mb_wdata <= ~b[b.size()-1];
		@(negedge clk);
		done = cmd_done;
	endtask
	// one mailbox byte read back
	task automatic get(input logic [4:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		mb_rd   <= 1'b1;
		mb_addr <= a;
		@(posedge clk);
		mb_rd <= 1'b0;
		@(negedge clk);
		d = mb_rdata;
		v = mb_rvalid;
	endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench of the low/high-g detector
`timescale 1ns/100ps
`default_nettype none
module tb
	import lhgd_pkg::*;
;
	logic         CLK = 1'b0;
	logic         ARST_N = 1'b0;
	logic         SAMPLE_VALID = 1'b0;
	lhgd_sample_t SAMPLE = '0;
	logic         MB_WR, MB_RD, MB_RVALID, CMD_DONE, ASLEEP, woke = 1'b0;
	logic [4:0]   MB_ADDR;
	logic [7:0]   MB_WDATA, MB_RDATA, lmin = 8'h08, lcfg = 8'h17, exp_st = 8'h00;
	logic [15:0]  lthr = 16'h03E8, hthr = 16'h1F40;
	logic [7:0]   lc[3] = '{3{8'h00}}, hc[3] = '{3{8'h00}};
	lhgd_status_t STATUS;
	int           n_mismatch = 0, checks_done = 0, cyc = 0;
	lhgd_detector i_lhgd_detector (.CLK(CLK), .ARST_N(ARST_N), .SAMPLE_VALID(SAMPLE_VALID),
		.SAMPLE(SAMPLE), .MB_WR(MB_WR), .MB_ADDR(MB_ADDR), .MB_WDATA(MB_WDATA), .MB_RD(MB_RD),
		.MB_RDATA(MB_RDATA), .MB_RVALID(MB_RVALID), .CMD_DONE(CMD_DONE), .STATUS(STATUS),
		.ASLEEP(ASLEEP));
	lhgd_host_model i_lhgd_host_model (.clk(CLK), .mb_wr(MB_WR), .mb_addr(MB_ADDR),
		.mb_wdata(MB_WDATA), .mb_rd(MB_RD), .mb_rdata(MB_RDATA), .mb_rvalid(MB_RVALID),
		.cmd_done(CMD_DONE));
	// clock and run ceiling
	always #4 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			close_out();
		end
	end
	// reference magnitude, debounce and axis values
	function automatic logic [15:0] mag(input logic [15:0] v);
		return (v == 16'h8000) ? 16'h7FFF : (v[15] ? -v : v);
	endfunction
	function automatic logic [7:0] deb(input logic c, input logic [7:0] n, m, input logic dm);
		if (c) return (n == 8'hFF) ? n : n + 8'h01;
		return (n < m && dm && n != 8'h00) ? n - 8'h01 : 8'h00;
	endfunction
	function automatic logic [15:0] pick(input int c);
		return c == 0 ? 16'($urandom_range(8'h00, 8'hFF)) : c == 1 ? 16'h8000
			: c == 2 ? -16'($urandom_range(16'h7000, 16'h7FFF)) : 16'($urandom);
	endfunction
	// expected status after one accepted sample
	task automatic step(input lhgd_sample_t s);
		logic [2:0] lf, hf;
		for (int i = 0; i < 3; i++) begin
			// a disabled axis keeps its counter at zero
			lc[i] = lcfg[i] ? deb(mag(s[16*i+:16]) < lthr, lc[i], lmin, lcfg[4])
				: 8'h00;
			hc[i] = deb(mag(s[16*i+:16]) > hthr, hc[i], 8'h08, 1'b1);
			lf[i] = lcfg[i] && lc[i] >= lmin;
			hf[i] = hc[i] >= 8'h08;
		end
		exp_st = {|hf, hf, lcfg[3] ? |lf : (lcfg[2:0] != 3'h0 && lf == lcfg[2:0]), lf};
	endtask
	// compare and count
	task automatic chk(input string nm, input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// counts and verdict
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one sample pulse, then status against the model
	task automatic samp(input lhgd_sample_t s);
		@(posedge CLK);
		SAMPLE       <= s;
		SAMPLE_VALID <= 1'b1;
		@(posedge CLK);
		SAMPLE_VALID <= 1'b0;
		if (woke) step(s);
		@(negedge CLK);
		chk("status", STATUS, exp_st);
	endtask
	// status read command, then the answer bytes
	task automatic rd_status(input logic [7:0] app);
		logic [7:0] d, e[$];
		logic       v;
		i_lhgd_host_model.send('{app, 8'h30, 8'h00, 8'h02}, v);
		chk("done", {7'h00, v}, 8'h01);
		if (app == 8'h09 || app == 8'h08) e = '{app, 8'h80, 8'h02, 8'h02, exp_st, 8'h00};
		else e = '{app, 8'h84, 8'h02, 8'h00};
		for (int i = 0; i < e.size(); i++) begin
			i_lhgd_host_model.get(i[4:0], d, v);
			chk("mailbox", d, e[i]);
			chk("rvalid", {7'h00, v}, 8'h01);
		end
	endtask
	// reset, asleep phase, wake, then random phases, all but the first with new settings
	initial begin
		logic       v;
		logic [7:0] d;
		int         c;
		c = $urandom(10647);
		repeat (10) @(posedge CLK);
		ARST_N <= 1'b1;
		@(negedge CLK);
		chk("asleep", {7'h00, ASLEEP}, 8'h01);
		repeat (8) samp('0);
		rd_status(8'h09);
		i_lhgd_host_model.send('{8'h12, 8'h20, 8'h06, 8'h01, 8'h00}, v);
		chk("awake", {6'h00, ASLEEP, v}, 8'h01);
		woke = 1'b1;
		for (int k = 0; k < 6; k++) begin
			if (k > 0) begin
				lthr = 16'($urandom_range(16'h0100, 16'h2000));
				hthr = 16'($urandom_range(16'h2001, 16'h6FFF));
				lmin = 8'($urandom_range(8'h01, 8'h04));
				lcfg = {3'h0, k[1:0], 3'($urandom)};
				i_lhgd_host_model.send('{8'h09, 8'h20, 8'h00, 8'h06, lthr[15:8], lthr[7:0],
					lmin, lcfg, hthr[15:8], hthr[7:0]}, v);
				chk("done", {7'h00, v}, 8'h01);
			end
			for (int n = 0; n < 40; n++) begin
				c = $urandom_range(0, 3);
				samp({pick(c), pick(c), pick(k[0] ? c : $urandom_range(0, 3))});
			end
			rd_status(8'h09);
		end
		rd_status(8'h05);
		// unknown app on a write: error answer, low threshold left alone
		i_lhgd_host_model.send('{8'h05, 8'h20, 8'h00, 8'h01, 8'h00}, v);
		chk("done", {7'h00, v}, 8'h01);
		i_lhgd_host_model.get(5'h01, d, v);
		chk("refused", d, 8'h84);
		for (int n = 0; n < 12; n++) samp({3{16'($urandom_range(0, 16'h0300))}});
		rd_status(8'h08);
		close_out();
	end
endmodule
`default_nettype wire
